// [hw/lsbx_exec.sv]
/*
 * Execution unit for logic, compare, indirect jump/call, skip and
 * flag-branch operations, with working registers, flags and program
 * counter. Assumes decoded instructions from same-clock logic and an
 * I/O register value on the same clock.
 */
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module lsbx_exec
	import lsbx_pkg::*;
#(
	parameter int PC_W = 16,
	parameter int REG_COUNT = 32
) (
	input wire logic clk, // 200 MHz system clock
	input wire logic rst, // synchronous reset, active high
	input wire lsbx_instr_s instr, // decoded instruction
	input wire logic instrValid, // instruction offered
	input wire logic [DATA_W-1:0] ioValue, // addressed I/O register
	input wire lsbx_bus_s bus, // register port request
	output logic [DATA_W-1:0] busRdData, // read data, cycle after
	output logic ready, // can take an instruction
	output logic done, // instruction finished pulse
	output logic [CYC_W-1:0] lastCycles, // cycles of last instruction
	output logic [PC_W-1:0] pc, // program counter
	output logic [DATA_W-1:0] flags, // flags_register
	output logic [PC_W-1:0] retAddr // return address of a call
);

	if (PC_W < 2 * DATA_W || REG_COUNT != (1 << RADDR_W)) begin : g_chk
		$error("unsupported program counter or register count");
	end

	function automatic logic [PC_W-1:0] pcAdd(
		input logic [PC_W-1:0] base,
		input logic [PC_W-1:0] delta
	);
		pcAdd = base + delta;
	endfunction : pcAdd

	function automatic logic [DATA_W-1:0] logicFlags(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] res
	);
		logic [DATA_W-1:0] f;
		f = old;
		f[FLAG_Z] = (res == DATA_ZERO);
		f[FLAG_N] = res[DATA_W-1];
		f[FLAG_V] = 1'b0;
		logicFlags = f;
	endfunction : logicFlags

	localparam logic [PC_W-1:0] PC_ONE = PC_W'(PC_STEP);
	localparam logic [PC_W-1:0] PC_SKIP1 = PC_W'(SKIP_ONE_WORD);
	localparam logic [PC_W-1:0] PC_SKIP2 = PC_W'(SKIP_TWO_WORD);
	localparam logic [PC_W-1:0] PC_BIAS = PC_W'(BRANCH_BIAS);
	localparam logic [PC_W-1:0] PC_RESET = '0;
	localparam logic [CYC_W-1:0] CNT_ZERO = '0;

	lsbx_state_e state_q, state_d;
	lsbx_instr_s cur_q;
	logic ioBit_q;
	logic [CYC_W-1:0] cnt_q;
	logic ready_q, done_q;
	logic [CYC_W-1:0] lastCycles_q;
	logic [PC_W-1:0] pc_q, retAddr_q;
	logic [DATA_W-1:0] flags_q;
	logic [DATA_W-1:0] rdA, rdB, rdC;
	logic [DATA_W-1:0] regRd_q;
	logic busRegSel_q;

	// ---------------- issue side ----------------
	wire accept = ready_q && instrValid;
	wire isPtrOp = (instr.op == OP_JMP_PTR) || (instr.op == OP_CALL_PTR);
	wire [RADDR_W-1:0] rdAddrA = isPtrOp ? PTR_LO : instr.dst;
	wire [RADDR_W-1:0] rdAddrB = isPtrOp ? PTR_HI : instr.src;
	wire execNow = (state_q == ST_EXEC);

	// ---------------- execute datapath ----------------
	wire lsbx_op_e op = cur_q.op;
	wire [DATA_W-1:0] orSrc = (op == OP_OR_REG) ? rdB : cur_q.imm;
	wire [DATA_W-1:0] orRes = rdA | orSrc;
	wire [DATA_W-1:0] clrRes = rdA & (CLEAR_BASE - cur_q.imm);
	wire [DATA_W-1:0] tstRes = rdA & rdA;
	wire isOr = (op == OP_OR_REG) || (op == OP_OR_IMM)
		|| (op == OP_SET_BITS);
	wire [DATA_W-1:0] logicRes = isOr ? orRes
		: (op == OP_CLR_BITS) ? clrRes : tstRes;
	wire isLogic = isOr || (op == OP_CLR_BITS) || (op == OP_TEST);
	wire regWrite = isOr || (op == OP_CLR_BITS);

	// compare: difference is never stored
	wire [DATA_W:0] diff = {1'b0, rdA} - {1'b0, cur_q.imm};
	wire [DATA_W-1:0] dr = diff[DATA_W-1:0];
	wire [DATA_W-1:0] ka = cur_q.imm;
	wire cmpH = (~rdA[3] & ka[3]) | (ka[3] & dr[3]) | (dr[3] & ~rdA[3]);
	wire cmpV = (rdA[7] & ~ka[7] & ~dr[7]) | (~rdA[7] & ka[7] & dr[7]);
	logic [DATA_W-1:0] cmpFlags;
	always_comb begin
		cmpFlags = flags_q;
		cmpFlags[FLAG_Z] = (dr == DATA_ZERO);
		cmpFlags[FLAG_N] = dr[DATA_W-1];
		cmpFlags[FLAG_V] = cmpV;
		cmpFlags[FLAG_C] = diff[DATA_W];
		cmpFlags[FLAG_H] = cmpH;
	end

	// skip conditions
	wire regBit = rdB[cur_q.bitSel];
	logic skipCond;
	always_comb begin
		case (op)
			OP_CMP_SKIP: skipCond = (rdA == rdB);
			OP_SKIP_RLO: skipCond = ~regBit;
			OP_SKIP_RHI: skipCond = regBit;
			OP_SKIP_IOLO: skipCond = ~ioBit_q;
			OP_SKIP_IOHI: skipCond = ioBit_q;
			default: skipCond = 1'b0;
		endcase
	end
	wire isSkip = (op == OP_CMP_SKIP) || (op == OP_SKIP_RLO)
		|| (op == OP_SKIP_RHI) || (op == OP_SKIP_IOLO)
		|| (op == OP_SKIP_IOHI);

	// branch on one selected flag
	wire flagBit = flags_q[cur_q.bitSel];
	wire isBranch = (op == OP_BR_HI) || (op == OP_BR_LO);
	wire brTaken = (op == OP_BR_HI) ? flagBit : ~flagBit;
	wire [PC_W-1:0] brOffset = {{(PC_W - OFFS_W){cur_q.offset[OFFS_W-1]}},
		cur_q.offset};
	wire [PC_W-1:0] brTarget = pcAdd(pcAdd(pc_q, brOffset), PC_BIAS);

	wire [PC_W-1:0] ptrTarget = PC_W'({rdB, rdA});
	wire [PC_W-1:0] pcNext1 = pcAdd(pc_q, PC_ONE);
	wire [PC_W-1:0] skipStep = cur_q.nextTwoWords ? PC_SKIP2 : PC_SKIP1;

	// next pc and cycle count of the instruction in execute
	logic [PC_W-1:0] execPc;
	logic [CYC_W-1:0] execCycles;
	always_comb begin
		execPc = pcNext1;
		execCycles = CYC_ONE;
		if (op == OP_JMP_PTR) begin
			execPc = ptrTarget;
			execCycles = CYC_TWO;
		end else if (op == OP_CALL_PTR) begin
			execPc = ptrTarget;
			execCycles = CYC_THREE;
		end else if (isSkip && skipCond) begin
			execPc = pcAdd(pc_q, skipStep);
			execCycles = cur_q.nextTwoWords ? CYC_THREE : CYC_TWO;
		end else if (isBranch && brTaken) begin
			execPc = brTarget;
			execCycles = CYC_TWO;
		end
	end

	// only logic and compare touch flags
	wire [DATA_W-1:0] execFlags = isLogic ? logicFlags(flags_q, logicRes)
		: (op == OP_CMP_IMM) ? cmpFlags : flags_q;

	// ---------------- register port ----------------
	wire busIsReg = (bus.addr < BADDR_W'(REG_COUNT));
	wire busRegWr = bus.wr && busIsReg;
	wire execRegWr = execNow && regWrite;
	// an execute write-back takes the port over a same-cycle bus write
	wire rfWrEn = execRegWr || busRegWr;
	wire [RADDR_W-1:0] rfWrAddr = execRegWr ? cur_q.dst
		: bus.addr[RADDR_W-1:0];
	wire [DATA_W-1:0] rfWrData = execRegWr ? logicRes : bus.wrData;
	wire busPcWr = !execNow && bus.wr;
	wire busFlagsWr = !execNow && bus.wr && (bus.addr == ADDR_FLAGS);

	wire [DATA_W-1:0] statusWord = {ready_q, done_q, 2'b00,
		lastCycles_q, state_q};
	logic [DATA_W-1:0] regRdNext;
	always_comb begin
		case (bus.addr)
			ADDR_FLAGS: regRdNext = flags_q;
			ADDR_PC_LO: regRdNext = pc_q[DATA_W-1:0];
			ADDR_PC_HI: regRdNext = pc_q[2*DATA_W-1:DATA_W];
			ADDR_STATUS: regRdNext = statusWord;
			ADDR_RET_LO: regRdNext = retAddr_q[DATA_W-1:0];
			ADDR_RET_HI: regRdNext = retAddr_q[2*DATA_W-1:DATA_W];
			default: regRdNext = DATA_ZERO;
		endcase
	end

	lsbx_regfile #(
		.WIDTH(DATA_W),
		.DEPTH(REG_COUNT),
		.AW(RADDR_W)
	) u_regs (
		.clk(clk),
		.wrEn(rfWrEn),
		.wrAddr(rfWrAddr),
		.wrData(rfWrData),
		.rdAddrA(rdAddrA),
		.rdAddrB(rdAddrB),
		.rdAddrC(bus.addr[RADDR_W-1:0]),
		.rdDataA(rdA),
		.rdDataB(rdB),
		.rdDataC(rdC)
	);

	// ---------------- sequencing ----------------
	wire stallEnd = (state_q == ST_STALL) && (cnt_q == CYC_ONE);
	wire finishNow = (execNow && execCycles == CYC_ONE) || stallEnd;

	always_comb begin
		case (state_q)
			ST_IDLE: state_d = accept ? ST_EXEC : ST_IDLE;
			ST_EXEC: state_d = (execCycles == CYC_ONE) ? ST_IDLE : ST_STALL;
			ST_STALL: state_d = stallEnd ? ST_IDLE : ST_STALL;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cnt_q <= CNT_ZERO;
			ready_q <= 1'b1;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ready_q <= (ready_q && !accept) || finishNow;
			done_q <= finishNow;
			if (execNow) begin
				cnt_q <= execCycles - CYC_ONE;
			end else if (state_q == ST_STALL) begin
				cnt_q <= cnt_q - CYC_ONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (accept) begin
			cur_q <= instr;
			ioBit_q <= ioValue[instr.bitSel];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pc_q <= PC_RESET;
			flags_q <= FLAGS_RESET;
			retAddr_q <= PC_RESET;
			lastCycles_q <= CNT_ZERO;
		end else if (execNow) begin
			pc_q <= execPc;
			flags_q <= execFlags;
			lastCycles_q <= execCycles;
			if (op == OP_CALL_PTR) begin
				retAddr_q <= pcNext1;
			end
		end else begin
			if (busFlagsWr) begin
				flags_q <= bus.wrData;
			end
			if (busPcWr && bus.addr == ADDR_PC_LO) begin
				pc_q[DATA_W-1:0] <= bus.wrData;
			end
			if (busPcWr && bus.addr == ADDR_PC_HI) begin
				pc_q[2*DATA_W-1:DATA_W] <= bus.wrData;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			regRd_q <= DATA_ZERO;
			busRegSel_q <= 1'b0;
		end else if (bus.rd) begin
			regRd_q <= regRdNext;
			busRegSel_q <= busIsReg;
		end
	end

	assign busRdData = busRegSel_q ? rdC : regRd_q;
	assign ready = ready_q;
	assign done = done_q;
	assign lastCycles = lastCycles_q;
	assign pc = pc_q;
	assign flags = flags_q;
	assign retAddr = retAddr_q;

endmodule : lsbx_exec

// [hw/lsbx_pkg.sv]
/*
 * Shared constants, types and encodings for the logic/skip/branch
 * execution unit. Assumes a single 200 MHz clock and synchronous reset.
 */
package lsbx_pkg;

	localparam int DATA_W = 8;
	localparam int RADDR_W = 5;
	localparam int BADDR_W = 6;
	localparam int OFFS_W = 7;
	localparam int CYC_W = 2;

	// flags_register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] CLEAR_BASE = 8'hFF;

	// pointer register pair (low, high)
	localparam logic [RADDR_W-1:0] PTR_LO = 5'h1E;
	localparam logic [RADDR_W-1:0] PTR_HI = 5'h1F;

	// program counter steps, in words
	localparam int PC_STEP = 1;
	localparam int SKIP_ONE_WORD = 2;
	localparam int SKIP_TWO_WORD = 3;
	localparam int BRANCH_BIAS = 1;

	// execution cycle counts
	localparam logic [CYC_W-1:0] CYC_ONE = 2'h1;
	localparam logic [CYC_W-1:0] CYC_TWO = 2'h2;
	localparam logic [CYC_W-1:0] CYC_THREE = 2'h3;

	// register port map; 0x00..0x1F are the working registers
	localparam logic [BADDR_W-1:0] ADDR_FLAGS = 6'h20;
	localparam logic [BADDR_W-1:0] ADDR_PC_LO = 6'h21;
	localparam logic [BADDR_W-1:0] ADDR_PC_HI = 6'h22;
	localparam logic [BADDR_W-1:0] ADDR_STATUS = 6'h23;
	localparam logic [BADDR_W-1:0] ADDR_RET_LO = 6'h24;
	localparam logic [BADDR_W-1:0] ADDR_RET_HI = 6'h25;

	typedef enum logic [3:0] {
		OP_OR_REG = 4'h0,
		OP_OR_IMM = 4'h1,
		OP_SET_BITS = 4'h2,
		OP_CLR_BITS = 4'h3,
		OP_TEST = 4'h4,
		OP_CMP_IMM = 4'h5,
		OP_JMP_PTR = 4'h6,
		OP_CALL_PTR = 4'h7,
		OP_CMP_SKIP = 4'h8,
		OP_SKIP_RLO = 4'h9,
		OP_SKIP_RHI = 4'hA,
		OP_SKIP_IOLO = 4'hB,
		OP_SKIP_IOHI = 4'hC,
		OP_BR_HI = 4'hD,
		OP_BR_LO = 4'hE
	} lsbx_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_STALL = 2'b11
	} lsbx_state_e;

	typedef struct packed {
		lsbx_op_e op;
		logic [RADDR_W-1:0] dst;
		logic [RADDR_W-1:0] src;
		logic [DATA_W-1:0] imm;
		logic [2:0] bitSel;
		logic [OFFS_W-1:0] offset;
		logic nextTwoWords;
	} lsbx_instr_s;

	typedef struct packed {
		logic [BADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
		logic wr;
		logic rd;
	} lsbx_bus_s;

endpackage : lsbx_pkg

// [hw/lsbx_regfile.sv]
/*
 * Working register file: one write port, three read ports with
 * registered read data. Assumes the caller never needs same-cycle
 * write-to-read bypass.
 */
`timescale 1ns/1ps
module lsbx_regfile #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic clk, // system clock
	input wire logic wrEn, // write strobe
	input wire logic [AW-1:0] wrAddr, // write address
	input wire logic [WIDTH-1:0] wrData, // write data
	input wire logic [AW-1:0] rdAddrA, // read address A
	input wire logic [AW-1:0] rdAddrB, // read address B
	input wire logic [AW-1:0] rdAddrC, // read address C
	output logic [WIDTH-1:0] rdDataA, // registered data A
	output logic [WIDTH-1:0] rdDataB, // registered data B
	output logic [WIDTH-1:0] rdDataC // registered data C
);

	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW)) begin : g_chk
		$error("regfile depth exceeds address range");
	end

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdDataA <= mem[rdAddrA];
		rdDataB <= mem[rdAddrB];
		rdDataC <= mem[rdAddrC];
	end

endmodule : lsbx_regfile

// [sim/lsbx_exec_properties.sv]
/* Concurrent checks on the lsbx_exec ports.
   Assumes one clock and an active-high synchronous reset. */
`timescale 1ns/1ps
module lsbx_exec_chk
	import lsbx_pkg::*;
#(
	parameter int PC_W = 16 // pc width
) (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire lsbx_instr_s instr, // instruction
	input wire logic instrValid, // offered
	input wire logic [DATA_W-1:0] ioValue, // io bits
	input wire lsbx_bus_s bus, // bus request
	input wire logic [DATA_W-1:0] busRdData, // read data
	input wire logic ready, // idle
	input wire logic done, // finish pulse
	input wire logic [CYC_W-1:0] lastCycles, // cycle count
	input wire logic [PC_W-1:0] pc, // pc
	input wire logic [DATA_W-1:0] flags, // flags
	input wire logic [PC_W-1:0] retAddr // return address
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	wire take = instrValid && ready;
	wire ioOp = instr.op == OP_SKIP_IOLO || instr.op == OP_SKIP_IOHI;
	wire ioHit = ioValue[instr.bitSel] == (instr.op == OP_SKIP_IOHI);
	wire brOp = instr.op == OP_BR_HI || instr.op == OP_BR_LO;
	wire brHit = flags[instr.bitSel] == (instr.op == OP_BR_HI);
	wire [PC_W-1:0] offs = PC_W'(signed'(instr.offset));
	property p_logic;
		take && instr.op <= OP_CMP_IMM |=> !done ##1 done &&
			lastCycles == CYC_ONE && pc == $past(pc, 2) + 16'h1;
	endproperty
	a_logic: assert property (p_logic) else $error("logic op");
	property p_jmp;
		take && instr.op == OP_JMP_PTR |=> !done[*2] ##1 done &&
			lastCycles == CYC_TWO && flags == $past(flags, 3);
	endproperty
	a_jmp: assert property (p_jmp) else $error("jump");
	property p_call;
		take && instr.op == OP_CALL_PTR |=> !done[*3] ##1 done &&
			lastCycles == CYC_THREE && retAddr == $past(pc, 4) + 16'h1;
	endproperty
	a_call: assert property (p_call) else $error("call");
	property p_skipFl;
		take && instr.op >= OP_CMP_SKIP && instr.op <= OP_SKIP_IOHI
			|=> $stable(flags)[*2];
	endproperty
	a_skipFl: assert property (p_skipFl) else $error("skip flags");
	property p_ioTwo;
		take && ioOp && ioHit && instr.nextTwoWords |=> !done[*3] ##1
			done && lastCycles == CYC_THREE && pc == $past(pc, 4) + 16'h3;
	endproperty
	a_ioTwo: assert property (p_ioTwo) else $error("io skip");
	property p_brT;
		take && brOp && brHit |=> !done[*2] ##1 done && lastCycles == CYC_TWO
			&& pc == $past(pc, 3) + $past(offs, 3) + 16'h1;
	endproperty
	a_brT: assert property (p_brT) else $error("branch taken");
	property p_brN;
		take && brOp && !brHit |=> !done ##1 done && lastCycles == CYC_ONE
			&& pc == $past(pc, 2) + 16'h1;
	endproperty
	a_brN: assert property (p_brN) else $error("branch untaken");
	property p_rdFl;
		bus.rd && bus.addr == ADDR_FLAGS && ready && !instrValid
			|=> busRdData == flags;
	endproperty
	a_rdFl: assert property (p_rdFl) else $error("flags read");
	c_call: cover property (take && instr.op == OP_CALL_PTR);
	c_io: cover property (take && ioOp && ioHit && instr.nextTwoWords);
	c_br: cover property (take && brOp && brHit);
endmodule : lsbx_exec_chk

bind lsbx_exec lsbx_exec_chk #(.PC_W(PC_W)) chk_u (.clk, .rst, .instr,
	.instrValid, .ioValue, .bus, .busRdData, .ready, .done, .lastCycles,
	.pc, .flags, .retAddr);

// [sim/lsbx_tb.sv]
/* Bench for lsbx_exec: bus and instruction tasks, directed tests.
   Assumes the package constants and a 200 MHz clock. */
`timescale 1ns/1ps
module tb
	import lsbx_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	lsbx_instr_s instr = '0;
	logic instrValid = 1'b0;
	logic [7:0] ioValue = 8'h00;
	lsbx_bus_s bus = '0;
	logic [7:0] busRdData, flags;
	logic [7:0] fl = 8'h28;
	logic ready, done, t, tw;
	logic [1:0] lastCycles;
	logic [15:0] pc, retAddr, pcExp, d;
	lsbx_op_e o;
	int s;
	int cyc = 0;
	int miscompares = 0;
	int checksDone = 0;

	lsbx_exec dut_u (.clk, .rst, .instr, .instrValid, .ioValue, .bus,
		.busRdData, .ready, .done, .lastCycles, .pc, .flags, .retAddr);

	initial forever #2.5 clk = ~clk;

	task automatic close_out();
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		checksDone++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic wr(int a, int v);
		@(posedge clk);
		bus <= '{6'(a), 8'(v), 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		#1;
	endtask : wr

	task automatic rc(int a, logic [7:0] e);
		@(posedge clk);
		bus <= '{6'(a), 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 d = {8'h00, busRdData};
		chk("busRdData", {8'h00, e}, d);
	endtask : rc

	task automatic fc(logic [7:0] e);
		chk("flags", {8'h00, e}, {8'h00, flags});
	endtask : fc

	// offer one instruction, time done, check pc
	task automatic ex(lsbx_op_e op, int ds, int sr, int k, int b, int of,
		int two, int n, logic [15:0] p);
		int c;
		c = 0;
		@(posedge clk);
		instr <= '{op, 5'(ds), 5'(sr), 8'(k), 3'(b), 7'(of), 1'(two)};
		instrValid <= 1'b1;
		@(posedge clk);
		instrValid <= 1'b0;
		#1 chk("readyBusy", 16'h0000, {15'h0000, ready});
		do begin
			@(posedge clk);
			#1 c++;
		end while (done !== 1'b1 && c < 6);
		chk("doneDelay", 16'(n), 16'(c));
		chk("readyDone", 16'h0001, {15'h0000, ready});
		chk("lastCycles", 16'(n), {14'h0, lastCycles});
		chk("pc", p, pc);
		pcExp = p;
	endtask : ex

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rc(ADDR_FLAGS, 8'h00);
		rc(ADDR_STATUS, 8'h80);
		rc('h3F, 8'h00);
		wr(ADDR_PC_LO, 'h10);
		wr(ADDR_PC_HI, 'h00);
		chk("pc", 16'h0010, pc);
		pcExp = 16'h0010;
		wr(1, 'h0F);
		wr(4, 'h80);
		wr(PTR_LO, 'h34);
		wr(PTR_HI, 'h12);
		wr(ADDR_FLAGS, 'h01);
		$display("test bus done");
		ex(OP_OR_REG, 1, 4, 0, 0, 0, 0, 1, pcExp + 16'h1);
		rc(1, 8'h8F);
		fc(8'h05);
		ex(OP_OR_IMM, 1, 0, 'h10, 0, 0, 0, 1, pcExp + 16'h1);
		rc(1, 8'h9F);
		ex(OP_SET_BITS, 1, 0, 'h20, 0, 0, 0, 1, pcExp + 16'h1);
		rc(1, 8'hBF);
		fc(8'h05);
		ex(OP_CLR_BITS, 1, 0, 'hBF, 0, 0, 0, 1, pcExp + 16'h1);
		rc(1, 8'h00);
		fc(8'h03);
		ex(OP_TEST, 1, 1, 0, 0, 0, 0, 1, pcExp + 16'h1);
		rc(1, 8'h00);
		fc(8'h03);
		ex(OP_CMP_IMM, 4, 0, 'h01, 0, 0, 0, 1, pcExp + 16'h1);
		rc(4, 8'h80);
		fc(8'h28);
		$display("test logic done");
		ex(OP_JMP_PTR, 0, 0, 0, 0, 0, 0, 2, 16'h1234);
		fc(8'h28);
		wr(PTR_LO, 'h78);
		wr(PTR_HI, 'h56);
		ex(OP_CALL_PTR, 0, 0, 0, 0, 0, 0, 3, 16'h5678);
		chk("retAddr", 16'h1235, retAddr);
		rc(ADDR_RET_LO, 8'h35);
		rc(ADDR_RET_HI, 8'h12);
		rc(ADDR_PC_LO, 8'h78);
		rc(ADDR_PC_HI, 8'h56);
		fc(8'h28);
		$display("test jump done");
		wr(3, 'hA5);
		for (int v = 0; v < 2; v++) begin
			wr(2, v ? 'hA4 : 'hA5);
			ioValue <= v ? 8'h00 : 8'h01;
			for (int i = 0; i < 10; i++) begin
				o = lsbx_op_e'(4'(OP_CMP_SKIP + i / 2));
				tw = 1'(i % 2);
				t = (o == OP_SKIP_RLO || o == OP_SKIP_IOLO) == (v == 1);
				s = t ? 2 + tw : 1;
				ex(o, 3, 2, 0, 0, 0, tw, s, 16'(pcExp + s));
			end
		end
		fc(8'h28);
		$display("test skip done");
		for (int b = 0; b < 16; b++) begin
			t = fl[b % 8] ^ (b > 7);
			s = t ? (b > 7 ? 6 : -3) : 1;
			ex(b > 7 ? OP_BR_LO : OP_BR_HI, 0, 0, 0, b, b > 7 ? 5 : 'h7C,
				0, t ? 2 : 1, 16'(pcExp + s));
		end
		fc(8'h28);
		$display("test branch done");
		close_out();
	end
endmodule : tb
